// File: general_output_signal_select.sv
// status pin select: three pins, each muxed from internal status signals
// assumes all status inputs are on aclk except the serial chip select pin
//
// Chosen here: the AXI4-Lite register port and the register addresses.
`timescale 1ns/10ps
`default_nettype none
module general_output_signal_select
  import gpo_pkg::*;
(
  input wire logic aclk,
  input wire logic aresetn,
  input wire logic [7:0] s_axi_awaddr,
  input wire logic s_axi_awvalid,
  output logic s_axi_awready,
  input wire logic [31:0] s_axi_wdata,
  input wire logic [3:0] s_axi_wstrb,
  input wire logic s_axi_wvalid,
  output logic s_axi_wready,
  output logic [1:0] s_axi_bresp,
  output logic s_axi_bvalid,
  input wire logic s_axi_bready,
  input wire logic [7:0] s_axi_araddr,
  input wire logic s_axi_arvalid,
  output logic s_axi_arready,
  output logic [31:0] s_axi_rdata,
  output logic [1:0] s_axi_rresp,
  output logic s_axi_rvalid,
  input wire logic s_axi_rready,
  input wire logic serial_chip_select_low,
  input wire logic sleep_state,
  input wire logic chip_ready_low,
  input wire logic rx_at_threshold,
  input wire logic rx_fifo_empty,
  input wire logic rx_overflow,
  input wire logic rx_flush,
  input wire logic rx_first_byte_read,
  input wire logic tx_at_threshold,
  input wire logic tx_fifo_full,
  input wire logic tx_underflow,
  input wire logic tx_flush,
  input wire logic sync_word_done,
  input wire logic packet_end,
  input wire logic address_fail,
  input wire logic crc_compare,
  input wire logic crc_match,
  input wire logic rx_enter,
  input wire logic [7:0] preamble_quality_estimate,
  input wire logic [7:0] preamble_quality_threshold,
  input wire logic clear_channel,
  input wire logic carrier_sense,
  input wire logic lock_detect,
  input wire logic serial_clock,
  input wire logic serial_sync_data,
  input wire logic serial_async_data,
  input wire logic [1:0] receive_symbol_decision,
  output logic status_pin_first_out,
  output logic status_pin_first_oe,
  output logic status_pin_second_out,
  output logic status_pin_second_oe,
  output logic status_pin_third_out,
  output logic status_pin_third_oe,
  output logic temp_sensor_enable
);

  logic [7:0] cfg [3];
  logic aw_held;
  logic w_held;
  logic [7:0] aw_addr;
  logic [31:0] w_data;
  logic [3:0] w_strb;
  logic cs_meta;
  logic cs_high;
  logic sleep_hold;
  logic [6:0] div_count;
  logic div_clk;
  logic flag_rx_pkt;
  logic flag_tx_full;
  logic flag_rx_ovf;
  logic flag_tx_unf;
  logic flag_sync;
  logic flag_crc_pkt;
  logic flag_crc_ok;
  logic [2:0] pin_out;
  logic [2:0] pin_oe;
  logic [2:0] next_out;
  logic [2:0] next_oe;
  logic [31:0] next_rdata;
  logic next_rerr;

  ////////////////////////////////////////////////////////////////////////
  // register write path
  assign s_axi_awready = !aw_held && !s_axi_bvalid;
  assign s_axi_wready = !w_held && !s_axi_bvalid;

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      aw_held <= 1'b0;
      w_held <= 1'b0;
      aw_addr <= 8'h00;
      w_data <= 32'h0000_0000;
      w_strb <= 4'h0;
      s_axi_bvalid <= 1'b0;
      s_axi_bresp <= RESP_OKAY;
    end else begin
      if (s_axi_awvalid && s_axi_awready) begin
        aw_held <= 1'b1;
        aw_addr <= s_axi_awaddr;
      end
      if (s_axi_wvalid && s_axi_wready) begin
        w_held <= 1'b1;
        w_data <= s_axi_wdata;
        w_strb <= s_axi_wstrb;
      end
      if (aw_held && w_held && !s_axi_bvalid) begin
        aw_held <= 1'b0;
        w_held <= 1'b0;
        s_axi_bvalid <= 1'b1;
        s_axi_bresp <= (aw_addr == REG_FIRST || aw_addr == REG_SECOND ||
                        aw_addr == REG_THIRD) ? RESP_OKAY : RESP_SLVERR;
      end else if (s_axi_bvalid && s_axi_bready) begin
        s_axi_bvalid <= 1'b0;
      end
    end
  end

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      cfg[0] <= RST_FIRST;
      cfg[1] <= RST_SECOND;
      cfg[2] <= RST_THIRD;
    end else if (aw_held && w_held && !s_axi_bvalid && w_strb[0]) begin
      if (aw_addr == REG_FIRST) begin
        cfg[0] <= w_data[7:0];
      end
      if (aw_addr == REG_SECOND) begin
        cfg[1] <= w_data[7:0];
      end
      if (aw_addr == REG_THIRD) begin
        cfg[2] <= w_data[7:0];
      end
    end
  end

  ////////////////////////////////////////////////////////////////////////
  // register read path
  assign s_axi_arready = !s_axi_rvalid;

  always_comb begin
    next_rerr = 1'b0;
    next_rdata = 32'h0000_0000;
    unique case (s_axi_araddr)
      REG_FIRST: next_rdata = {24'h00_0000, cfg[0]};
      REG_SECOND: next_rdata = {24'h00_0000, cfg[1]};
      REG_THIRD: next_rdata = {24'h00_0000, cfg[2]};
      REG_STATUS: next_rdata = {25'h000_0000, sleep_hold, pin_oe, pin_out};
      default: next_rerr = 1'b1;
    endcase
  end

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      s_axi_rvalid <= 1'b0;
      s_axi_rdata <= 32'h0000_0000;
      s_axi_rresp <= RESP_OKAY;
    end else if (s_axi_arvalid && s_axi_arready) begin
      s_axi_rvalid <= 1'b1;
      s_axi_rdata <= next_rdata;
      s_axi_rresp <= next_rerr ? RESP_SLVERR : RESP_OKAY;
    end else if (s_axi_rvalid && s_axi_rready) begin
      s_axi_rvalid <= 1'b0;
    end
  end

  ////////////////////////////////////////////////////////////////////////
  // chip select synchroniser and sleep hold
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      cs_meta <= 1'b0;
      cs_high <= 1'b0;
    end else begin
      cs_meta <= serial_chip_select_low;
      cs_high <= cs_meta;
    end
  end

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      sleep_hold <= 1'b0;
    end else begin
      sleep_hold <= sleep_state || (sleep_hold && chip_ready_low);
    end
  end

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      div_count <= 7'h00;
      div_clk <= 1'b0;
    end else if (div_count == DIV_HALF_LAST) begin
      div_count <= 7'h00;
      div_clk <= !div_clk;
    end else begin
      div_count <= div_count + 7'h01;
    end
  end

  ////////////////////////////////////////////////////////////////////////
  // sticky event flags, set wins over clear
  // packet or threshold
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      flag_rx_pkt <= 1'b0;
    end else begin
      flag_rx_pkt <= rx_at_threshold || packet_end ||
                     (flag_rx_pkt && !rx_fifo_empty);
    end
  end

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      flag_tx_full <= 1'b0;
    end else begin
      flag_tx_full <= tx_fifo_full || (flag_tx_full && tx_at_threshold);
    end
  end

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      flag_rx_ovf <= 1'b0;
      flag_tx_unf <= 1'b0;
    end else begin
      flag_rx_ovf <= rx_overflow || (flag_rx_ovf && !rx_flush);
      flag_tx_unf <= tx_underflow || (flag_tx_unf && !tx_flush);
    end
  end

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      flag_sync <= 1'b0;
    end else begin
      flag_sync <= sync_word_done || (flag_sync && !packet_end &&
                   !address_fail && !rx_overflow && !tx_underflow);
    end
  end

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      flag_crc_pkt <= 1'b0;
      flag_crc_ok <= 1'b0;
    end else begin
      flag_crc_pkt <= (crc_compare && crc_match) ||
                      (flag_crc_pkt && !rx_first_byte_read);
      if (crc_compare) begin
        flag_crc_ok <= crc_match;
      end else if (rx_enter) begin
        flag_crc_ok <= 1'b0;
      end
    end
  end

  ////////////////////////////////////////////////////////////////////////
  // per pin select, inversion, sleep forcing
  always_comb begin
    logic raw;
    logic inv;
    logic [5:0] sel;
    raw = 1'b0;
    inv = 1'b0;
    sel = 6'h00;
    for (int i = 0; i < 3; i++) begin
      sel = cfg[i][5:0];
      inv = cfg[i][INV_BIT];
      next_oe[i] = 1'b1;
      unique case (sel)
        SEL_RX_THR: raw = rx_at_threshold;
        SEL_RX_PKT: raw = flag_rx_pkt;
        SEL_TX_THR: raw = tx_at_threshold;
        SEL_TX_FULL: raw = flag_tx_full;
        SEL_RX_OVF: raw = flag_rx_ovf;
        SEL_TX_UNF: raw = flag_tx_unf;
        SEL_SYNC: raw = flag_sync;
        SEL_CRC_PKT: raw = flag_crc_pkt;
        SEL_PQ: raw = preamble_quality_estimate > preamble_quality_threshold;
        SEL_CCA: raw = clear_channel;
        SEL_LOCK: raw = lock_detect;
        SEL_SCLK: raw = serial_clock;
        SEL_SYNC_DATA: raw = serial_sync_data;
        SEL_ASYNC_DATA: raw = serial_async_data;
        SEL_CS: raw = carrier_sense;
        SEL_CRC_OK: raw = flag_crc_ok;
        SEL_HARD1: raw = receive_symbol_decision[1];
        SEL_HARD0: raw = receive_symbol_decision[0];
        SEL_DIV192: raw = div_clk;
        SEL_HIZ: begin
          raw = 1'b0;
          next_oe[i] = 1'b0;
        end
        default: raw = 1'b0;
      endcase
      next_out[i] = raw ^ inv;
      if (sleep_hold && sel < SEL_SLEEP_LIMIT) begin
        next_out[i] = (i == 1) ? !inv : inv;
        next_oe[i] = 1'b1;
      end
    end
    // temperature sensor takes the first pin
    if (cfg[0] == TEMP_SENSOR_CODE) begin
      next_oe[0] = 1'b0;
      next_out[0] = 1'b0;
    end
    if (!cs_high) begin
      next_oe[1] = 1'b0;
    end
  end

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      pin_out <= 3'h0;
      pin_oe <= 3'h0;
    end else begin
      pin_out <= next_out;
      pin_oe <= next_oe;
    end
  end

  assign status_pin_first_out = pin_out[0];
  assign status_pin_first_oe = pin_oe[0];
  assign status_pin_second_out = pin_out[1];
  assign status_pin_second_oe = pin_oe[1];
  assign status_pin_third_out = pin_out[2];
  assign status_pin_third_oe = pin_oe[2];
  assign temp_sensor_enable = cfg[0] == TEMP_SENSOR_CODE;

  ////////////////////////////////////////////////////////////////////////
  // checks
  AST_SECOND_CS_GATE: assert property (@(posedge aclk) disable iff (!aresetn)
    !$past(cs_high) |-> !status_pin_second_oe)
    else $error("second pin driven while chip select low");

  AST_SECOND_RESET: assert property (@(posedge aclk)
    $past(!aresetn) |-> cfg[1] == RST_SECOND && !status_pin_second_oe)
    else $error("second pin not tri-stated after reset");

  AST_FIRST_RESET: assert property (@(posedge aclk)
    $past(!aresetn) |-> cfg[0] == RST_FIRST)
    else $error("first pin default select wrong");

  AST_DIV_PERIOD: assert property (@(posedge aclk) disable iff (!aresetn)
    $rose(div_clk) |-> ##96 $fell(div_clk))
    else $error("divided clock half period not 96");

  AST_TEMP_SENSOR: assert property (@(posedge aclk) disable iff (!aresetn)
    cfg[0] == TEMP_SENSOR_CODE |-> temp_sensor_enable ##1 !status_pin_first_oe)
    else $error("temperature sensor code still drives first pin");

  AST_SLEEP_FORCE: assert property (@(posedge aclk) disable iff (!aresetn)
    sleep_hold && cfg[2][5:0] < SEL_SLEEP_LIMIT |=>
      status_pin_third_oe && status_pin_third_out == $past(cfg[2][INV_BIT]))
    else $error("third pin not forced in sleep");

  AST_SLEEP_RELEASE: assert property (@(posedge aclk) disable iff (!aresetn)
    sleep_state ##1 (!sleep_state && chip_ready_low)[*2] |-> sleep_hold)
    else $error("sleep levels released before chip ready");

  AST_RX_OVF_STICKY: assert property (@(posedge aclk) disable iff (!aresetn)
    flag_rx_ovf && !rx_flush |=> flag_rx_ovf)
    else $error("overflow flag dropped without flush");

  AST_RX_PKT_CLEAR: assert property (@(posedge aclk) disable iff (!aresetn)
    rx_fifo_empty && !rx_at_threshold && !packet_end |=> !flag_rx_pkt)
    else $error("receive packet flag not cleared on empty");

  AST_HIZ_CODE: assert property (@(posedge aclk) disable iff (!aresetn)
    cfg[2][5:0] == SEL_HIZ |=> !status_pin_third_oe)
    else $error("tri-state code drives third pin");

  AST_CONST_CODE: assert property (@(posedge aclk) disable iff (!aresetn)
    cfg[2][5:0] == SEL_LOW |=> status_pin_third_out == $past(cfg[2][INV_BIT]))
    else $error("constant code level wrong");

endmodule
`default_nettype wire

// File: gpo_pkg.sv
// constants for the status pin select block
// assumes one 200 MHz clock and a 32-bit AXI4-Lite register port
package gpo_pkg;
  localparam logic [7:0] REG_FIRST = 8'h00;
  localparam logic [7:0] REG_SECOND = 8'h04;
  localparam logic [7:0] REG_THIRD = 8'h08;
  localparam logic [7:0] REG_STATUS = 8'h0C;
  localparam logic [7:0] RST_FIRST = 8'h3F;
  localparam logic [7:0] RST_SECOND = 8'h2E;
  localparam logic [7:0] RST_THIRD = 8'h2F;
  localparam logic [7:0] TEMP_SENSOR_CODE = 8'h80;
  localparam int INV_BIT = 6;
  localparam logic [5:0] SEL_RX_THR = 6'h00;
  localparam logic [5:0] SEL_RX_PKT = 6'h01;
  localparam logic [5:0] SEL_TX_THR = 6'h02;
  localparam logic [5:0] SEL_TX_FULL = 6'h03;
  localparam logic [5:0] SEL_RX_OVF = 6'h04;
  localparam logic [5:0] SEL_TX_UNF = 6'h05;
  localparam logic [5:0] SEL_SYNC = 6'h06;
  localparam logic [5:0] SEL_CRC_PKT = 6'h07;
  localparam logic [5:0] SEL_PQ = 6'h08;
  localparam logic [5:0] SEL_CCA = 6'h09;
  localparam logic [5:0] SEL_LOCK = 6'h0A;
  localparam logic [5:0] SEL_SCLK = 6'h0B;
  localparam logic [5:0] SEL_SYNC_DATA = 6'h0C;
  localparam logic [5:0] SEL_ASYNC_DATA = 6'h0D;
  localparam logic [5:0] SEL_CS = 6'h0E;
  localparam logic [5:0] SEL_CRC_OK = 6'h0F;
  localparam logic [5:0] SEL_HARD1 = 6'h16;
  localparam logic [5:0] SEL_HARD0 = 6'h17;
  localparam logic [5:0] SEL_SLEEP_LIMIT = 6'h20;
  localparam logic [5:0] SEL_HIZ = 6'h2E;
  localparam logic [5:0] SEL_LOW = 6'h2F;
  localparam logic [5:0] SEL_DIV192 = 6'h3F;
  localparam int CRYSTAL_DIVIDE = 192;
  localparam logic [6:0] DIV_HALF_LAST = 7'(CRYSTAL_DIVIDE / 2 - 1);
  localparam logic [1:0] RESP_OKAY = 2'h0;
  localparam logic [1:0] RESP_SLVERR = 2'h2;
endpackage

// File: status_host.sv
// host model: reads the three status pins as a microcontroller would
// assumes pin levels and enables from the block, all on aclk
`timescale 1ns/10ps
`default_nettype none
module status_host (
  input wire logic aclk,
  input wire logic [2:0] pin_out,
  input wire logic [2:0] pin_oe,
  output logic [2:0] pin_level,
  output logic lock_seen
);
  logic [2:0] last = 3'h0;
  //////////////////////////////////////////////////////////////////////////
  always_ff @(posedge aclk) begin
    last <= pin_oe & pin_out | ~pin_oe & last;
  end
  assign pin_level = pin_oe & pin_out | ~pin_oe & ~last;
  always_ff @(posedge aclk) begin
    lock_seen <= pin_level[2];
  end
endmodule
`default_nettype wire

// File: tb.sv
// self-checking bench for the status pin select block
// assumes the host model is compiled first; bench acts as bus master
`timescale 1ns/10ps
`default_nettype none
module tb;
  import gpo_pkg::*;
  `define CHK(a, b) begin tests_run++; if ((a) !== (b)) begin failures++; \
    $display("unexpected at %0t: got %h want %h", $time, a, b); end end
  localparam logic [5:0] LV [13] = '{6'h00, 6'h02, 6'h08, 6'h09, 6'h0A,
    6'h0B, 6'h0C, 6'h0D, 6'h0E, 6'h16, 6'h17, 6'h10, 6'h2F};
  localparam int ST [8][3] = '{'{4, 0, 1}, '{5, 3, 4}, '{6, 5, 6},
    '{6, 5, 7}, '{6, 5, 0}, '{7, 8, 2}, '{15, 8, 9}, '{6, 5, 3}};
  logic aclk = 0, aresetn = 0;
  logic [7:0] s_axi_awaddr = 0, s_axi_araddr = 0;
  logic [31:0] s_axi_wdata = 0, s_axi_rdata, rd;
  logic [3:0] s_axi_wstrb = 0;
  logic s_axi_awvalid = 0, s_axi_wvalid = 0, s_axi_bready = 0;
  logic s_axi_arvalid = 0, s_axi_rready = 0;
  logic s_axi_awready, s_axi_wready, s_axi_bvalid, s_axi_arready;
  logic s_axi_rvalid;
  logic [1:0] s_axi_bresp, s_axi_rresp, resp;
  logic serial_chip_select_low = 1, sleep_state = 0, chip_ready_low = 0;
  logic rx_at_threshold = 0, rx_fifo_empty = 0, tx_at_threshold = 0;
  logic tx_fifo_full = 0, crc_match = 1, rx_overflow = 0, rx_flush = 0;
  logic rx_first_byte_read = 0, tx_underflow = 0, tx_flush = 0;
  logic sync_word_done = 0, packet_end = 0, address_fail = 0;
  logic crc_compare = 0, rx_enter = 0;
  logic [7:0] preamble_quality_estimate = 0, preamble_quality_threshold = 0;
  logic clear_channel = 0, carrier_sense = 0, lock_detect = 0;
  logic serial_clock = 0, serial_sync_data = 0, serial_async_data = 0;
  logic [1:0] receive_symbol_decision = 0;
  logic status_pin_first_out, status_pin_first_oe, status_pin_second_out;
  logic status_pin_second_oe, status_pin_third_out, status_pin_third_oe;
  logic temp_sensor_enable, lock_seen;
  logic [2:0] pin_level;
  logic [15:0] seed = 16'h258F;
  int failures = 0, tests_run = 0;
  always #2.5 aclk = ~aclk;
  general_output_signal_select u_dut (.aclk, .aresetn, .s_axi_awaddr,
    .s_axi_awvalid, .s_axi_awready, .s_axi_wdata, .s_axi_wstrb,
    .s_axi_wvalid, .s_axi_wready, .s_axi_bresp, .s_axi_bvalid,
    .s_axi_bready, .s_axi_araddr, .s_axi_arvalid, .s_axi_arready,
    .s_axi_rdata, .s_axi_rresp, .s_axi_rvalid, .s_axi_rready,
    .serial_chip_select_low, .sleep_state, .chip_ready_low,
    .rx_at_threshold, .rx_fifo_empty, .rx_overflow, .rx_flush,
    .rx_first_byte_read, .tx_at_threshold, .tx_fifo_full, .tx_underflow,
    .tx_flush, .sync_word_done, .packet_end, .address_fail, .crc_compare,
    .crc_match, .rx_enter, .preamble_quality_estimate,
    .preamble_quality_threshold, .clear_channel, .carrier_sense,
    .lock_detect, .serial_clock, .serial_sync_data, .serial_async_data,
    .receive_symbol_decision, .status_pin_first_out, .status_pin_first_oe,
    .status_pin_second_out, .status_pin_second_oe, .status_pin_third_out,
    .status_pin_third_oe, .temp_sensor_enable);
  status_host u_host (.aclk,
    .pin_out({status_pin_third_out, status_pin_second_out,
      status_pin_first_out}),
    .pin_oe({status_pin_third_oe, status_pin_second_oe, status_pin_first_oe}),
    .pin_level, .lock_seen);
  //////////////////////////////////////////////////////////////////////////
  function automatic logic [15:0] nx(logic [15:0] s);
    return {s[14:0], s[15] ^ s[13] ^ s[12] ^ s[10]};
  endfunction
  function automatic logic lvl(logic [5:0] c);
    case (c)
      SEL_RX_THR: return rx_at_threshold;
      SEL_TX_THR: return tx_at_threshold;
      SEL_PQ: return preamble_quality_estimate > preamble_quality_threshold;
      SEL_CCA: return clear_channel;
      SEL_LOCK: return lock_detect;
      SEL_SCLK: return serial_clock;
      SEL_SYNC_DATA: return serial_sync_data;
      SEL_ASYNC_DATA: return serial_async_data;
      SEL_CS: return carrier_sense;
      SEL_HARD1: return receive_symbol_decision[1];
      SEL_HARD0: return receive_symbol_decision[0];
      default: return 1'b0;
    endcase
  endfunction
  task automatic tick(int n);
    repeat (n) @(posedge aclk);
    #1;
  endtask
  task automatic axw(logic [7:0] a, logic [7:0] d);
    bit ta, tw, tk;
    @(posedge aclk);
    s_axi_awaddr <= a;
    s_axi_wdata <= {24'h0, d};
    s_axi_wstrb <= 4'hF;
    s_axi_awvalid <= 1'b1;
    s_axi_wvalid <= 1'b1;
    s_axi_bready <= 1'b1;
    do begin
      @(negedge aclk);
      ta = s_axi_awvalid && s_axi_awready;
      tw = s_axi_wvalid && s_axi_wready;
      tk = s_axi_bvalid && s_axi_bready;
      resp = s_axi_bresp;
      @(posedge aclk);
      if (ta) s_axi_awvalid <= 1'b0;
      if (tw) s_axi_wvalid <= 1'b0;
      if (tk) s_axi_bready <= 1'b0;
    end while (!tk);
  endtask
  task automatic axr(logic [7:0] a);
    bit ta, tk;
    @(posedge aclk);
    s_axi_araddr <= a;
    s_axi_arvalid <= 1'b1;
    s_axi_rready <= 1'b1;
    do begin
      @(negedge aclk);
      ta = s_axi_arvalid && s_axi_arready;
      tk = s_axi_rvalid && s_axi_rready;
      resp = s_axi_rresp;
      rd = s_axi_rdata;
      @(posedge aclk);
      if (ta) s_axi_arvalid <= 1'b0;
      if (tk) s_axi_rready <= 1'b0;
    end while (!tk);
  endtask
  task automatic drv(int i, logic v);
    case (i)
      0: rx_overflow <= v;
      1: rx_flush <= v;
      2: rx_first_byte_read <= v;
      3: tx_underflow <= v;
      4: tx_flush <= v;
      5: sync_word_done <= v;
      6: packet_end <= v;
      7: address_fail <= v;
      8: crc_compare <= v;
      default: rx_enter <= v;
    endcase
  endtask
  task automatic pulse(int i);
    @(posedge aclk);
    drv(i, 1'b1);
    @(posedge aclk);
    drv(i, 1'b0);
    tick(3);
  endtask
  task automatic shuffle();
    @(posedge aclk);
    seed = nx(seed);
    {rx_at_threshold, rx_fifo_empty, tx_at_threshold, tx_fifo_full,
      clear_channel, carrier_sense, lock_detect, serial_clock} <= seed[7:0];
    {serial_sync_data, serial_async_data, receive_symbol_decision}
      <= seed[11:8];
    preamble_quality_estimate <= {seed[3:0], seed[15:12]};
    preamble_quality_threshold <= seed[15:8];
    tick(3);
  endtask
  task automatic close_out();
    $display("comparisons %0d mismatches %0d", tests_run, failures);
    if (failures == 0 && tests_run > 0)
      $display("DONE - PASS");
    else
      $display("DONE - FAIL");
    $finish;
  endtask
  //////////////////////////////////////////////////////////////////////////
  initial begin
    #100000;
    failures++;
    close_out();
  end
  initial begin
    int n;
    logic v;
    repeat (16) @(posedge aclk);
    aresetn <= 1'b1;
    axr(REG_FIRST);
    `CHK(rd, 32'(RST_FIRST))
    axr(REG_SECOND);
    `CHK(rd, 32'(RST_SECOND))
    `CHK(status_pin_second_oe, 1'b0)
    `CHK(pin_level[2], 1'b0)
    for (int k = 0; k < 2; k++) begin
      n = 0;
      v = status_pin_first_out;
      while (status_pin_first_out === v && n < 300) begin
        tick(1);
        n++;
      end
    end
    `CHK(n, 96)
    $display("test reset done");
    for (int i = 0; i < 13; i++) begin
      for (int k = 0; k < 2; k++) begin
        axw(REG_THIRD, {1'b0, k[0], LV[i]});
        repeat (4) begin
          shuffle();
          `CHK(pin_level[2], lvl(LV[i]) ^ k[0])
          if (LV[i] == SEL_LOCK) `CHK(lock_seen, lock_detect ^ k[0])
        end
      end
    end
    $display("test levels done");
    for (int i = 0; i < 8; i++) begin
      axw(REG_THIRD, 8'(ST[i][0]));
      pulse(ST[i][2]);
      `CHK(pin_level[2], 1'b0)
      pulse(ST[i][1]);
      tick(5);
      `CHK(pin_level[2], 1'b1)
      pulse(ST[i][2]);
      `CHK(pin_level[2], 1'b0)
    end
    axw(REG_THIRD, {2'b00, SEL_HIZ});
    tick(2);
    `CHK(status_pin_third_oe, 1'b0)
    axw(REG_THIRD, {2'b00, SEL_RX_PKT});
    @(posedge aclk);
    {rx_at_threshold, rx_fifo_empty, tx_at_threshold, tx_fifo_full} <= 4'h2;
    pulse(6);
    `CHK(pin_level[2], 1'b1)
    @(posedge aclk);
    rx_fifo_empty <= 1'b1;
    tick(3);
    `CHK(pin_level[2], 1'b0)
    axw(REG_THIRD, {2'b00, SEL_TX_FULL});
    @(posedge aclk);
    tx_fifo_full <= 1'b1;
    @(posedge aclk);
    tx_fifo_full <= 1'b0;
    tick(3);
    `CHK(pin_level[2], 1'b1)
    @(posedge aclk);
    tx_at_threshold <= 1'b0;
    tick(3);
    `CHK(pin_level[2], 1'b0)
    $display("test flags done");
    axw(REG_THIRD, 8'h42);
    axw(REG_SECOND, 8'h40);
    @(posedge aclk);
    sleep_state <= 1'b1;
    chip_ready_low <= 1'b1;
    tx_at_threshold <= 1'b1;
    tick(4);
    `CHK(pin_level[2], 1'b1)
    `CHK(pin_level[1], 1'b0)
    @(posedge aclk);
    sleep_state <= 1'b0;
    tick(4);
    `CHK(pin_level[2], 1'b1)
    @(posedge aclk);
    chip_ready_low <= 1'b0;
    tick(4);
    `CHK(pin_level[2], 1'b0)
    `CHK(pin_level[1], 1'b1)
    axw(REG_SECOND, 8'h6F);
    sleep_state <= 1'b1;
    chip_ready_low <= 1'b1;
    tick(4);
    `CHK(pin_level[1], 1'b1)
    @(posedge aclk);
    sleep_state <= 1'b0;
    chip_ready_low <= 1'b0;
    serial_chip_select_low <= 1'b0;
    tick(5);
    `CHK(status_pin_second_oe, 1'b0)
    @(posedge aclk);
    serial_chip_select_low <= 1'b1;
    tick(5);
    `CHK(pin_level[1], 1'b1)
    $display("test sleep done");
    axw(REG_FIRST, TEMP_SENSOR_CODE);
    `CHK(resp, RESP_OKAY)
    tick(2);
    `CHK(temp_sensor_enable, 1'b1)
    `CHK(status_pin_first_oe, 1'b0)
    axw(REG_FIRST, 8'h6F);
    tick(2);
    `CHK(pin_level[0], 1'b1)
    axr(8'h40);
    `CHK(resp, RESP_SLVERR)
    `CHK(rd, 32'h0)
    axr(REG_STATUS);
    `CHK(rd, 32'h0000_003B)
    $display("test bus done");
    close_out();
  end
endmodule
`default_nettype wire
